//--- design/t16_filter.v
// noise filter in front of the capture edge detector
// assumes its input is already synchronised to sys_clk
`timescale 1ns/10ps
module t16_filter #(
  parameter LEN = 4
) (
  input  wire sys_clk,
  input  wire rstn,
  input  wire enable,
  input  wire sample,
  output reg  level
);

  reg [LEN-1:0] history;

  // ------------------------------------------------------------
  // sample history and output
  // ------------------------------------------------------------
  // runs on the undivided clock so the prescaler never stretches it
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      history <= {LEN{1'b0}};
      level   <= 1'b0;
    end else begin
      history <= {history[LEN-2:0], sample};
      if (!enable) begin
        level <= sample;
      end else if (&history) begin
        level <= 1'b1;
      end else if (~|history) begin
        level <= 1'b0;
      end
    end
  end

endmodule // t16_filter

//--- design/t16_timer.v
// 16-bit timer/counter with input capture and shared high-byte register
// assumes a processor core on an 8-bit i/o bus, one access per cycle
//
// What this block does
// - three-bit clock select in control b picks internal or external tick
// - each tick counts up or down by one, or clears, per mode
// - bottom flags counter at zero, top flags end of count sequence
// - low byte access moves upper byte via holding register; upper reaches holder
// - clock select zero stops counting; processor access still works
// - processor counter write beats a same-cycle clear or count
// - four-bit waveform mode, split over control a and b, sets sequence
// - overflow flag set where the mode says, may request an interrupt
// - selected edge on the trigger copies the counter into capture value
// - capture flag set with the copy; interrupt when enable bit is one
// - capture flag clears on interrupt service or writing one to it
// - capture low read loads holder; later upper read returns holder
// - capture value writable only in modes using it as top
// - comparator capture select picks comparator output as trigger
// - filter and edge detector keep running but capture is blocked when capture value defines top
// - filter output changes only after four equal new samples
// - filter enabled in control b, runs on system clock, adds four cycles
// - every new capture overwrites the capture value
// - driving the capture pin from port logic can trigger a capture
// - one holding register serves every 16-bit register here
// - counter reaches maximum at 0xFFFF whatever the mode top
`timescale 1ns/10ps
`include "t16_map.vh"
module t16_timer (
  input  wire       sys_clk,
  input  wire       rstn,
  input  wire [5:0] io_addr,
  input  wire       io_wr,
  input  wire       io_rd,
  input  wire [7:0] io_wdata,
  output reg  [7:0] io_rdata,
  input  wire       capture_input_pin,
  input  wire       comparator_output,
  input  wire       external_count_pin,
  input  wire       capture_irq_ack,
  input  wire       overflow_irq_ack,
  output reg        capture_irq,
  output reg        overflow_irq,
  output reg        at_top,
  output reg        at_bottom
);

  reg  [7:0]  timer_control_a;
  reg  [7:0]  timer_control_b;
  reg  [7:0]  comparator_ctrl_status;
  reg  [7:0]  irq_mask;
  reg  [15:0] count_value;
  reg  [15:0] capture_value;
  reg  [7:0]  holding;
  reg         count_down;
  reg         capture_flag;
  reg         overflow_flag;
  reg  [`T16_PS_WIDTH-1:0] prescale;
  reg  [1:0]  pin_sync;
  reg  [1:0]  cmp_sync;
  reg  [1:0]  ext_sync;
  reg         ext_prev;
  reg         filt_prev;
  wire        filt_level;
  wire [3:0]  waveform_mode_field;
  wire [2:0]  clock_source_select;
  wire [15:0] top_value;
  reg         timer_tick;
  reg  [15:0] next_count;
  reg         next_down;
  reg         ovf_event;
  reg         next_capture_flag;
  reg         next_overflow_flag;
  wire        cnt_write;
  wire        cap_write;
  wire        flag_write;
  wire        capture_enabled;
  wire        edge_seen;
  wire        capture_event;

  // ------------------------------------------------------------
  // mode decoding
  // ------------------------------------------------------------
  function cap_is_top;
    input [3:0] mode;
    begin
      cap_is_top = (mode == 4'h8) || (mode == 4'hA) ||
                   (mode == 4'hC) || (mode == 4'hE);
    end
  endfunction

  function dual_slope;
    input [3:0] mode;
    begin
      dual_slope = (mode == 4'h1) || (mode == 4'h2) || (mode == 4'h3) ||
                   (mode == 4'h8) || (mode == 4'hA);
    end
  endfunction

  function [15:0] top_of;
    input [3:0]  mode;
    input [15:0] cap;
    begin
      case (mode)
        4'h1, 4'h5: top_of = `T16_TOP_8BIT;
        4'h2, 4'h6: top_of = `T16_TOP_9BIT;
        4'h3, 4'h7: top_of = `T16_TOP_10BIT;
        4'h8, 4'hA, 4'hC, 4'hE: top_of = cap;
        // compare-register tops live outside this block
        default: top_of = `T16_MAX;
      endcase
    end
  endfunction

  assign waveform_mode_field = {timer_control_b[`T16_B_WGM_HI],
                                timer_control_a[`T16_A_WGM_LO]};
  assign clock_source_select = timer_control_b[`T16_B_CS];
  assign top_value = top_of(waveform_mode_field, capture_value);

  // ------------------------------------------------------------
  // access strobes
  // ------------------------------------------------------------
  assign cnt_write  = io_wr && (io_addr == `T16_ADR_CNT_LO);
  assign cap_write  = io_wr && (io_addr == `T16_ADR_CAP_LO) &&
                      cap_is_top(waveform_mode_field);
  assign flag_write = io_wr && (io_addr == `T16_ADR_IRQ_FLAG);

  // ------------------------------------------------------------
  // synchronisers and prescaler
  // ------------------------------------------------------------
  // first stages feed only the second stages
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync <= 2'h0;
      cmp_sync <= 2'h0;
      ext_sync <= 2'h0;
      ext_prev <= 1'b0;
      prescale <= {`T16_PS_WIDTH{1'b0}};
    end else begin
      pin_sync <= {pin_sync[0], capture_input_pin};
      cmp_sync <= {cmp_sync[0], comparator_output};
      ext_sync <= {ext_sync[0], external_count_pin};
      ext_prev <= ext_sync[1];
      prescale <= prescale + {{(`T16_PS_WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @* begin
    case (clock_source_select)
      `T16_CS_STOP:     timer_tick = 1'b0;
      `T16_CS_DIV1:     timer_tick = 1'b1;
      `T16_CS_DIV8:     timer_tick = (prescale[2:0] == `T16_PS_DIV8);
      `T16_CS_DIV64:    timer_tick = (prescale[5:0] == `T16_PS_DIV64);
      `T16_CS_DIV256:   timer_tick = (prescale[7:0] == `T16_PS_DIV256);
      `T16_CS_DIV1024:  timer_tick = (prescale == `T16_PS_DIV1024);
      `T16_CS_EXT_FALL: timer_tick = ext_prev & ~ext_sync[1];
      `T16_CS_EXT_RISE: timer_tick = ~ext_prev & ext_sync[1];
      default:          timer_tick = 1'b0;
    endcase
  end

  // ------------------------------------------------------------
  // counter sequence
  // ------------------------------------------------------------
  always @* begin
    next_count = count_value;
    next_down  = count_down;
    ovf_event  = 1'b0;
    if (cnt_write) begin
      next_count = {holding, io_wdata};
    end else if (timer_tick) begin
      if (dual_slope(waveform_mode_field)) begin
        if (!count_down && (count_value >= top_value)) begin
          next_down  = 1'b1;
          next_count = count_value - `T16_ONE;
        end else if (count_down && (count_value == `T16_BOTTOM)) begin
          next_down  = 1'b0;
          next_count = count_value + `T16_ONE;
          ovf_event  = 1'b1;
        end else if (count_down) begin
          next_count = count_value - `T16_ONE;
        end else begin
          next_count = count_value + `T16_ONE;
        end
      end else begin
        next_down = 1'b0;
        // past a lowered top the count runs on to maximum and wraps
        if ((count_value == top_value) ||
            (count_value == `T16_MAX)) begin
          next_count = `T16_BOTTOM;
          ovf_event  = 1'b1;
        end else begin
          next_count = count_value + `T16_ONE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // capture trigger
  // ------------------------------------------------------------
  t16_filter #(
    .LEN (`T16_FILTER_LEN)
  ) u_filter (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .enable  (timer_control_b[`T16_B_FILTER]),
    .sample  (comparator_ctrl_status[`T16_CMP_CAPSEL] ?
              cmp_sync[1] : pin_sync[1]),
    .level   (filt_level)
  );

  assign capture_enabled = ~cap_is_top(waveform_mode_field);
  assign edge_seen = timer_control_b[`T16_B_EDGE] ?
                     (filt_level & ~filt_prev) :
                     (~filt_level & filt_prev);
  assign capture_event = capture_enabled & edge_seen;

  // ------------------------------------------------------------
  // flags
  // ------------------------------------------------------------
  // a new event in the clearing cycle keeps the flag set
  always @* begin
    next_capture_flag = capture_event | (capture_flag &
      ~(capture_irq_ack |
        (flag_write & io_wdata[`T16_BIT_CAPTURE])));
    next_overflow_flag = ovf_event | (overflow_flag &
      ~(overflow_irq_ack |
        (flag_write & io_wdata[`T16_BIT_OVERFLOW])));
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count_value   <= `T16_BOTTOM;
      count_down    <= 1'b0;
      capture_value <= `T16_BOTTOM;
      capture_flag  <= 1'b0;
      overflow_flag <= 1'b0;
      capture_irq   <= 1'b0;
      overflow_irq  <= 1'b0;
      filt_prev     <= 1'b0;
      at_top        <= 1'b0;
      at_bottom     <= 1'b1;
    end else begin
      count_value  <= next_count;
      count_down   <= next_down;
      filt_prev    <= filt_level;
      capture_flag  <= next_capture_flag;
      overflow_flag <= next_overflow_flag;
      capture_irq  <= next_capture_flag &
                      irq_mask[`T16_BIT_CAPTURE];
      overflow_irq <= next_overflow_flag & irq_mask[`T16_BIT_OVERFLOW];
      at_top       <= (next_count == top_value);
      at_bottom    <= (next_count == `T16_BOTTOM);
      if (capture_event) begin
        capture_value <= count_value;
      end else if (cap_write) begin
        capture_value <= {holding, io_wdata};
      end
    end
  end

  // ------------------------------------------------------------
  // control registers and holding register
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      timer_control_a        <= `T16_RESET_BYTE;
      timer_control_b        <= `T16_RESET_BYTE;
      comparator_ctrl_status <= `T16_RESET_BYTE;
      irq_mask               <= `T16_RESET_BYTE;
      holding                <= `T16_RESET_BYTE;
    end else begin
      if (io_wr) begin
        case (io_addr)
          `T16_ADR_CTRL_A:   timer_control_a <= io_wdata;
          `T16_ADR_CTRL_B:   timer_control_b <= io_wdata;
          `T16_ADR_CMP_CTRL: comparator_ctrl_status <= io_wdata;
          `T16_ADR_IRQ_MASK: irq_mask <= io_wdata;
          // one holder for every upper byte, so accesses overwrite it
          `T16_ADR_CNT_HI,
          `T16_ADR_CAP_HI:   holding <= io_wdata;
          default: ;
        endcase
      end else if (io_rd) begin
        case (io_addr)
          `T16_ADR_CNT_LO: holding <= count_value[15:8];
          `T16_ADR_CAP_LO: holding <= capture_value[15:8];
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= `T16_RESET_BYTE;
    end else if (io_rd) begin
      case (io_addr)
        `T16_ADR_CTRL_A:   io_rdata <= timer_control_a;
        `T16_ADR_CTRL_B:   io_rdata <= timer_control_b;
        `T16_ADR_CNT_LO:   io_rdata <= count_value[7:0];
        `T16_ADR_CNT_HI,
        `T16_ADR_CAP_HI:   io_rdata <= holding;
        `T16_ADR_CAP_LO:   io_rdata <= capture_value[7:0];
        `T16_ADR_IRQ_MASK: io_rdata <= irq_mask;
        `T16_ADR_IRQ_FLAG: io_rdata <= {overflow_flag, 1'b0, capture_flag,
                                        5'h00};
        `T16_ADR_CMP_CTRL: io_rdata <= comparator_ctrl_status;
        default:           io_rdata <= `T16_RESET_BYTE;
      endcase
    end
  end

endmodule // t16_timer

//--- pkg/t16_map.vh
// register map, field positions and fixed values of the 16-bit timer
// assumes an 8-bit i/o bus with a 6-bit address from the processor core
`ifndef T16_MAP_VH
`define T16_MAP_VH

// ------------------------------------------------------------
// i/o locations
// ------------------------------------------------------------
`define T16_ADR_CTRL_A     6'h00
`define T16_ADR_CTRL_B     6'h01
`define T16_ADR_CNT_LO     6'h02
`define T16_ADR_CNT_HI     6'h03
`define T16_ADR_CAP_LO     6'h04
`define T16_ADR_CAP_HI     6'h05
`define T16_ADR_IRQ_MASK   6'h06
`define T16_ADR_IRQ_FLAG   6'h07
`define T16_ADR_CMP_CTRL   6'h08

// ------------------------------------------------------------
// fields
// ------------------------------------------------------------
`define T16_A_WGM_LO       1:0
`define T16_B_CS           2:0
`define T16_B_WGM_HI       4:3
`define T16_B_EDGE         6
`define T16_B_FILTER       7
`define T16_CMP_CAPSEL     2
`define T16_BIT_CAPTURE    5
`define T16_BIT_OVERFLOW   7

// ------------------------------------------------------------
// clock select codes and prescaler taps
// ------------------------------------------------------------
`define T16_CS_STOP        3'h0
`define T16_CS_DIV1        3'h1
`define T16_CS_DIV8        3'h2
`define T16_CS_DIV64       3'h3
`define T16_CS_DIV256      3'h4
`define T16_CS_DIV1024     3'h5
`define T16_CS_EXT_FALL    3'h6
`define T16_CS_EXT_RISE    3'h7
`define T16_PS_WIDTH       10
`define T16_PS_DIV8        10'h007
`define T16_PS_DIV64       10'h03F
`define T16_PS_DIV256      10'h0FF
`define T16_PS_DIV1024     10'h3FF

// ------------------------------------------------------------
// counting values
// ------------------------------------------------------------
`define T16_BOTTOM         16'h0000
`define T16_MAX            16'hFFFF
`define T16_TOP_8BIT       16'h00FF
`define T16_TOP_9BIT       16'h01FF
`define T16_TOP_10BIT      16'h03FF
`define T16_ONE            16'h0001
`define T16_RESET_BYTE     8'h00
`define T16_FILTER_LEN     4

`endif

//--- testbench/t16_chk_checker.sv
// concurrent checks on the ports of the 16-bit timer
// assumes the i/o map of t16_map.vh and one bus access per cycle
`timescale 1ns/10ps
`include "t16_map.vh"
module t16_chk (
  input wire       sys_clk,
  input wire       rstn,
  input wire [5:0] io_addr,
  input wire       io_wr,
  input wire       io_rd,
  input wire [7:0] io_wdata,
  input wire [7:0] io_rdata,
  input wire       capture_input_pin,
  input wire       comparator_output,
  input wire       capture_irq_ack,
  input wire       capture_irq,
  input wire       at_top,
  input wire       at_bottom
);
  // ------------------------------------------------------------
  // shadow of the bus writes
  // ------------------------------------------------------------
  reg [7:0] hold;
  reg       hok;
  reg [3:0] mode;
  reg [2:0] cb;
  reg       msk;
  reg [3:0] quiet;
  reg [1:0] last;
  wire      ctop = mode[3] && !mode[0];
  wire      cfg  = !ctop && cb[0] && !cb[2] && msk && !capture_irq;
  function automatic wa(input [5:0] x);
    wa = io_wr && io_addr == x;
  endfunction
  default clocking dck @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // quiet counts edges without trigger activity, so a late capture
  // is never taken for a clear that failed
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold  <= 8'h00;
      hok   <= 1'b1;
      mode  <= 4'h0;
      cb    <= 3'h0;
      msk   <= 1'b0;
      quiet <= 4'h0;
      last  <= 2'h0;
    end else begin
      last <= {comparator_output, capture_input_pin};
      if (wa(`T16_ADR_CNT_HI) || wa(`T16_ADR_CAP_HI)) begin
        hold <= io_wdata;
        hok  <= 1'b1;
      end else if (io_rd && (io_addr == `T16_ADR_CNT_LO ||
                             io_addr == `T16_ADR_CAP_LO))
        hok <= 1'b0;
      if (wa(`T16_ADR_CTRL_A))
        mode[1:0] <= io_wdata[1:0];
      if (wa(`T16_ADR_CTRL_B)) begin
        {cb[1], cb[0]} <= io_wdata[7:6];
        mode[3:2]      <= io_wdata[4:3];
      end
      if (wa(`T16_ADR_CMP_CTRL))
        cb[2] <= io_wdata[`T16_CMP_CAPSEL];
      if (wa(`T16_ADR_IRQ_MASK))
        msk <= io_wdata[`T16_BIT_CAPTURE];
      if (wa(`T16_ADR_CTRL_A) || wa(`T16_ADR_CTRL_B) ||
          wa(`T16_ADR_CMP_CTRL) ||
          last != {comparator_output, capture_input_pin})
        quiet <= 4'h0;
      else if (quiet != 4'hF)
        quiet <= quiet + 4'h1;
    end
  end
  sequence s_rise;
    $rose(capture_input_pin) && cfg && !cb[1];
  endsequence
  sequence s_frise;
    $rose(capture_input_pin) && cfg && cb[1] ##1 capture_input_pin[*4];
  endsequence
  sequence s_clr;
    (capture_irq_ack ||
     wa(`T16_ADR_IRQ_FLAG) && io_wdata[`T16_BIT_CAPTURE]) &&
    quiet > 4'hB;
  endsequence
  a_rdata_holds: assert property (
    !$past(io_rd) |-> $stable(io_rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (
    io_rd && !io_wr && io_addr > `T16_ADR_CMP_CTRL |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bottom_write: assert property (
    wa(`T16_ADR_CNT_LO) && hok |=>
    at_bottom == ({$past(hold), $past(io_wdata)} == `T16_BOTTOM))
    else $error("bottom wrong after write");
  a_max_write: assert property (
    wa(`T16_ADR_CNT_LO) && hok && mode == 4'h0 |=>
    at_top == ({$past(hold), $past(io_wdata)} == `T16_MAX))
    else $error("top wrong after write");
  a_irq_mask: assert property (
    capture_irq |-> msk || $past(msk)) else $error("irq while masked");
  a_flag_clear: assert property (
    s_clr |-> ##[1:2] !capture_irq) else $error("flag not cleared");
  a_cap_latency: assert property (
    s_rise |-> ##1 (!capture_irq)[*3] ##1 capture_irq)
    else $error("capture latency wrong");
  a_filt_latency: assert property (
    s_frise |-> !capture_irq ##[2:4] capture_irq)
    else $error("filtered capture latency wrong");
  a_cap_refused: assert property (
    $rose(capture_input_pin) && ctop && msk && !capture_irq && !cb[1]
    |-> (!capture_irq)[*6]) else $error("capture in top mode");
endmodule // t16_chk
bind t16_timer t16_chk u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
  .io_rdata(io_rdata), .capture_input_pin(capture_input_pin),
  .comparator_output(comparator_output),
  .capture_irq_ack(capture_irq_ack), .capture_irq(capture_irq),
  .at_top(at_top), .at_bottom(at_bottom));

//--- testbench/t16_src.sv
// event source standing in for the pins that feed the timer
// assumes the bench calls put just after a rising edge
`timescale 1ns/10ps
module t16_src (
  output reg capture_input_pin,
  output reg comparator_output,
  output reg external_count_pin
);
  initial begin
    {external_count_pin, comparator_output, capture_input_pin} = 3'h0;
  end
  // driving the pin from port logic is how software makes a capture
  task put(input [2:0] lv);
    {external_count_pin, comparator_output, capture_input_pin} = lv;
  endtask
endmodule // t16_src

//--- testbench/t16_timer_tb.sv
// self-checking bench for the 16-bit timer with input capture
// assumes the map of t16_map.vh and the checker bound to the timer
`timescale 1ns/10ps
`include "t16_map.vh"
module t16_timer_tb;
  reg         sys_clk;
  reg         rstn;
  reg  [5:0]  io_addr;
  reg         io_wr;
  reg         io_rd;
  reg  [7:0]  io_wdata;
  reg         capture_irq_ack;
  reg         overflow_irq_ack;
  wire [7:0]  io_rdata;
  wire [2:0]  pins;
  wire        capture_irq;
  wire        overflow_irq;
  wire        at_top;
  wire        at_bottom;
  integer     bad_count;
  integer     num_checks;
  integer     seed;
  integer     cycles;
  integer     i;
  reg  [15:0] v;
  reg  [7:0]  exp_q[$];
  reg         rd_q;
  t16_src u_src (.capture_input_pin(pins[0]), .comparator_output(pins[1]),
    .external_count_pin(pins[2]));
  t16_timer u_dut (.sys_clk(sys_clk), .rstn(rstn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .capture_input_pin(pins[0]), .comparator_output(pins[1]),
    .external_count_pin(pins[2]), .capture_irq_ack(capture_irq_ack),
    .overflow_irq_ack(overflow_irq_ack), .capture_irq(capture_irq),
    .overflow_irq(overflow_irq), .at_top(at_top), .at_bottom(at_bottom));
  // ------------------------------------------------------------
  // bus tasks, comparison and the closing report
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task check(input string what, input [15:0] seen, input [15:0] expv);
    num_checks = num_checks + 1;
    if (seen !== expv) begin
      $display("unexpected %s exp %h seen %h", what, expv, seen);
      bad_count = bad_count + 1;
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // a strobe always drops for one cycle, so no signal is set twice
  task acc(input w, input [5:0] a, input [7:0] d);
    {io_addr, io_wdata, io_wr, io_rd} = {a, d, w, !w};
    tick(1);
    {io_wr, io_rd} = 2'b00;
    tick(1);
  endtask
  task rd(input [5:0] a, input [7:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 8'h00);
  endtask
  task wr16(input [5:0] lo, input [15:0] x);
    acc(1'b1, lo + 6'h01, x[15:8]);
    acc(1'b1, lo, x[7:0]);
  endtask
  task rd16(input [5:0] lo, input [15:0] x);
    rd(lo, x[7:0]);
    rd(lo + 6'h01, x[15:8]);
  endtask
  task cap(input [2:0] lv, input integer n, input e);
    u_src.put(lv);
    tick(n);
    check("capture irq", {15'h0000, capture_irq}, {15'h0000, e});
  endtask
  always @(posedge sys_clk) begin
    if (rd_q)
      check("read data", {8'h00, io_rdata}, {8'h00, exp_q.pop_front()});
    rd_q = io_rd;
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  initial begin
    {rstn, io_addr, io_wr, io_rd, io_wdata, capture_irq_ack, rd_q} = 0;
    overflow_irq_ack = 1'b0;
    {bad_count, num_checks, cycles} = 0;
    seed = 80;
    tick(8);
    rstn = 1'b1;
    check("bottom", {15'h0000, at_bottom}, 16'h0001);
    rd16(`T16_ADR_CNT_LO, 16'h0000);
    repeat (4) begin
      v = 16'($random(seed));
      wr16(`T16_ADR_CNT_LO, v);
      tick(3);
      rd16(`T16_ADR_CNT_LO, v);
    end
    rd(`T16_ADR_CNT_LO, v[7:0]);
    rd(`T16_ADR_CAP_HI, v[15:8]);
    rd(6'h3F, 8'h00);
    acc(1'b1, 6'h3F, 8'hFF);
    rd16(`T16_ADR_CNT_LO, v);
    wr16(`T16_ADR_CNT_LO, `T16_MAX);
    check("top", {15'h0000, at_top}, 16'h0001);
    $display("test bus done");
    acc(1'b1, `T16_ADR_CTRL_B, 8'h01);
    wr16(`T16_ADR_CNT_LO, 16'h00FF);
    rd16(`T16_ADR_CNT_LO, 16'h0100);
    // the wrap out of 0xFFFF above left the overflow flag set
    acc(1'b1, `T16_ADR_IRQ_FLAG, 8'h80);
    acc(1'b1, `T16_ADR_IRQ_MASK, 8'h80);
    wr16(`T16_ADR_CNT_LO, 16'hFFFD);
    check("overflow irq", {15'h0000, overflow_irq}, 16'h0000);
    tick(2);
    check("overflow irq", {15'h0000, overflow_irq}, 16'h0001);
    overflow_irq_ack = 1'b1;
    tick(1);
    overflow_irq_ack = 1'b0;
    check("overflow irq", {15'h0000, overflow_irq}, 16'h0000);
    acc(1'b1, `T16_ADR_CTRL_A, 8'h01);
    wr16(`T16_ADR_CNT_LO, 16'h00FE);
    tick(2);
    rd16(`T16_ADR_CNT_LO, 16'h00FD);
    acc(1'b1, `T16_ADR_CTRL_A, 8'h00);
    for (i = 6; i < 8; i = i + 1) begin
      acc(1'b1, `T16_ADR_CTRL_B, i[7:0]);
      wr16(`T16_ADR_CNT_LO, 16'h0000);
      repeat (4) begin
        cap({!i[0], 2'b00}, 3, 1'b0);
        cap({i[0], 2'b00}, 3, 1'b0);
      end
      tick(4);
      rd16(`T16_ADR_CNT_LO, 16'h0004);
    end
    $display("test count done");
    acc(1'b1, `T16_ADR_IRQ_MASK, 8'h20);
    acc(1'b1, `T16_ADR_CTRL_B, 8'h40);
    wr16(`T16_ADR_CNT_LO, 16'h1234);
    cap(3'b001, 3, 1'b0);
    cap(3'b001, 1, 1'b1);
    rd16(`T16_ADR_CAP_LO, 16'h1234);
    acc(1'b1, `T16_ADR_IRQ_FLAG, 8'h20);
    cap(3'b000, 8, 1'b0);
    acc(1'b1, `T16_ADR_CTRL_B, 8'h00);
    acc(1'b1, `T16_ADR_IRQ_FLAG, 8'h20);
    cap(3'b001, 8, 1'b0);
    wr16(`T16_ADR_CNT_LO, 16'h9ABC);
    cap(3'b000, 4, 1'b1);
    rd16(`T16_ADR_CAP_LO, 16'h9ABC);
    cap(3'b000, 8, 1'b1);
    capture_irq_ack = 1'b1;
    cap(3'b000, 1, 1'b0);
    capture_irq_ack = 1'b0;
    cap(3'b000, 2, 1'b0);
    $display("test capture done");
    acc(1'b1, `T16_ADR_CTRL_B, 8'hC0);
    cap(3'b001, 3, 1'b0);
    cap(3'b000, 8, 1'b0);
    cap(3'b001, 7, 1'b0);
    cap(3'b001, 1, 1'b1);
    acc(1'b1, `T16_ADR_CTRL_B, 8'h40);
    acc(1'b1, `T16_ADR_CMP_CTRL, 8'h04);
    tick(8);
    acc(1'b1, `T16_ADR_IRQ_FLAG, 8'h20);
    cap(3'b000, 8, 1'b0);
    cap(3'b001, 8, 1'b0);
    cap(3'b011, 4, 1'b1);
    acc(1'b1, `T16_ADR_CMP_CTRL, 8'h00);
    tick(8);
    acc(1'b1, `T16_ADR_IRQ_FLAG, 8'h20);
    $display("test filter done");
    acc(1'b1, `T16_ADR_CTRL_B, 8'h58);
    acc(1'b1, `T16_ADR_CNT_HI, 8'h3C);
    acc(1'b1, `T16_ADR_CAP_LO, 8'h11);
    acc(1'b1, `T16_ADR_CNT_LO, 8'h22);
    rd16(`T16_ADR_CAP_LO, 16'h3C11);
    rd16(`T16_ADR_CNT_LO, 16'h3C22);
    cap(3'b010, 3, 1'b0);
    cap(3'b011, 8, 1'b0);
    acc(1'b1, `T16_ADR_CTRL_B, 8'h40);
    wr16(`T16_ADR_CAP_LO, 16'hFFFF);
    rd16(`T16_ADR_CAP_LO, 16'h3C11);
    $display("test mode done");
    tick(2);
    summarize;
  end
endmodule // t16_timer_tb
